// ===== logic/tx_seq_defs.svh
`ifndef TX_SEQ_DEFS_SVH
`define TX_SEQ_DEFS_SVH

// ----------------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------------
`define OFS_MODE_CTRL 4'h0
`define OFS_VALIDATE 4'h4
`define OFS_TX_POINTER 4'h8
`define OFS_VALID_FLAGS 4'hC

// ----------------------------------------------------------------------------
// Element layout and control field bit positions
// ----------------------------------------------------------------------------
`define NUM_ELEMS 16
`define QW_PER_ELEM 10
`define QW_PREPEND 4'h8
`define QW_CONTROL 4'h9
`define CTL_TXERR 18
`define CTL_TXASIS 17
`define CTL_PREPEND 16
`define CTL_QW_HI 15
`define CTL_QW_LO 13
`define CTL_BYTES_HI 12
`define CTL_BYTES_LO 10
`define CTL_EOP 9
`define CTL_SOP 8
`define CTL_ERR 7
`define CTL_MAC_HI 5
`define CTL_MAC_LO 3
`define CTL_PORT_HI 2
`define CTL_PORT_LO 0

// ----------------------------------------------------------------------------
// Reset values and bus answers
// ----------------------------------------------------------------------------
`define MODE_RESET 1'h0
`define PTR_RESET 4'h0
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// ===== logic/tx_seq_pkg.sv
package tx_seq_pkg;

  typedef enum logic [1:0]
  {
    ST_CHECK = 2'h0,
    ST_PREPEND = 2'h1,
    ST_DATA = 2'h3
  } seq_state_type;

endpackage : tx_seq_pkg

// ===== logic/element_flag.sv
`timescale 1ns/1ps

// A sticky flag where a set in the same cycle as a clear wins.
module element_flag
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic set_pulse,
  input wire logic clear_pulse,
  output logic flag
);

  logic flag_reg;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      flag_reg <= 1'b0;
    else if (set_pulse)
      flag_reg <= 1'b1;
    else if (clear_pulse)
      flag_reg <= 1'b0;
  end

  assign flag = flag_reg;

endmodule : element_flag

// ===== logic/transmit_element_sequencer.sv
`timescale 1ns/1ps
`include "tx_seq_defs.svh"

module transmit_element_sequencer
#(
  parameter int NUM_ELEMS = `NUM_ELEMS
)
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic fill_valid,
  input wire logic [3:0] fill_elem,
  input wire logic [3:0] fill_qword,
  input wire logic [63:0] fill_data,
  input wire logic mem_done_valid,
  input wire logic [3:0] mem_done_elem,
  input wire logic mem_done_sig_req,
  output logic mem_thread_signal,
  output logic [3:0] mem_thread_elem,
  output logic tx_valid,
  input wire logic tx_ready,
  output logic [63:0] tx_data,
  output logic [7:0] tx_byte_valid,
  output logic tx_sop,
  output logic tx_eop,
  output logic tx_err,
  output logic tx_asis,
  output logic [2:0] tx_mac,
  output logic [2:0] tx_port
);

  // --------------------------------------------------------------------------
  // Element storage and valid flags
  // --------------------------------------------------------------------------
  logic [63:0] elem_mem [NUM_ELEMS][`QW_PER_ELEM];
  logic [NUM_ELEMS-1:0] first_flags;
  logic [NUM_ELEMS-1:0] second_flags;
  logic [NUM_ELEMS-1:0] first_set;
  logic [NUM_ELEMS-1:0] second_set;
  logic [NUM_ELEMS-1:0] flag_clear;
  logic validate_hit;
  logic [3:0] validate_elem;
  logic clr_en;
  logic [3:0] clr_idx;

  always_ff @(posedge aclk)
  begin
    if (fill_valid && fill_qword <= `QW_CONTROL)
      elem_mem[fill_elem][fill_qword] <= fill_data;
  end

  for (genvar i = 0; i < NUM_ELEMS; i++)
  begin : g_flags
    assign first_set[i] = validate_hit && validate_elem == 4'(i);
    assign second_set[i] = mem_done_valid && mem_done_elem == 4'(i);
    assign flag_clear[i] = clr_en && clr_idx == 4'(i);
    element_flag u_first
    (
      .aclk(aclk),
      .aresetn(aresetn),
      .set_pulse(first_set[i]),
      .clear_pulse(flag_clear[i]),
      .flag(first_flags[i])
    );
    element_flag u_second
    (
      .aclk(aclk),
      .aresetn(aresetn),
      .set_pulse(second_set[i]),
      .clear_pulse(flag_clear[i]),
      .flag(second_flags[i])
    );
  end

  // Completion is reported to the waiting thread only when it asked for it.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      mem_thread_signal <= 1'b0;
      mem_thread_elem <= 4'h0;
    end
    else
    begin
      mem_thread_signal <= mem_done_valid && mem_done_sig_req;
      mem_thread_elem <= mem_done_elem;
    end
  end

  // --------------------------------------------------------------------------
  // Register bus slave
  // --------------------------------------------------------------------------
  logic dual_mode_reg;
  logic [3:0] ptr_reg;
  logic aw_have_reg;
  logic w_have_reg;
  logic [3:0] aw_addr_reg;
  logic [31:0] w_data_reg;
  logic w_lane0_reg;
  logic do_write;

  assign s_axi_awready = !aw_have_reg && !s_axi_bvalid;
  assign s_axi_wready = !w_have_reg && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  assign do_write = aw_have_reg && w_have_reg;
  assign validate_hit = do_write && aw_addr_reg == `OFS_VALIDATE && w_lane0_reg;
  assign validate_elem = w_data_reg[3:0];

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_have_reg <= 1'b0;
      w_have_reg <= 1'b0;
      aw_addr_reg <= 4'h0;
      w_data_reg <= 32'h0;
      w_lane0_reg <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `RESP_OKAY;
      dual_mode_reg <= `MODE_RESET;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_have_reg <= 1'b1;
        aw_addr_reg <= s_axi_awaddr[3:0];
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_have_reg <= 1'b1;
        w_data_reg <= s_axi_wdata;
        w_lane0_reg <= s_axi_wstrb[0];
      end
      if (do_write)
      begin
        aw_have_reg <= 1'b0;
        w_have_reg <= 1'b0;
        s_axi_bvalid <= 1'b1;
        if (aw_addr_reg == `OFS_MODE_CTRL)
        begin
          s_axi_bresp <= `RESP_OKAY;
          if (w_lane0_reg)
            dual_mode_reg <= w_data_reg[0];
        end
        else if (aw_addr_reg == `OFS_VALIDATE)
          s_axi_bresp <= `RESP_OKAY;
        else
          s_axi_bresp <= `RESP_SLVERR;
      end
      else if (s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  // Read offsets above the decoded word range do not alias onto bits 3:0; any set bit in 31:4 reads zero with SLVERR.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= `RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= `RESP_OKAY;
      if (s_axi_araddr[31:4] != 28'h0)
      begin
        s_axi_rdata <= 32'h0;
        s_axi_rresp <= `RESP_SLVERR;
      end
      else if (s_axi_araddr[3:0] == `OFS_MODE_CTRL)
        s_axi_rdata <= {31'h0, dual_mode_reg};
      else if (s_axi_araddr[3:0] == `OFS_TX_POINTER)
        s_axi_rdata <= {28'h0, ptr_reg};
      else if (s_axi_araddr[3:0] == `OFS_VALID_FLAGS)
        s_axi_rdata <= {second_flags, first_flags};
      else
      begin
        s_axi_rdata <= 32'h0;
        s_axi_rresp <= `RESP_SLVERR;
      end
    end
    else if (s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end

  // --------------------------------------------------------------------------
  // Sequencer
  // --------------------------------------------------------------------------
  tx_seq_pkg::seq_state_type state_reg;
  logic [3:0] cur_reg;
  logic [63:0] ctrl_reg;
  logic [2:0] beat_reg;
  logic first_beat_reg;
  logic [63:0] ptr_ctrl;
  logic elem_ready;
  logic out_free;
  logic emit;
  logic last_beat;
  logic [3:0] nbytes;

  assign ptr_ctrl = elem_mem[ptr_reg][`QW_CONTROL];
  assign elem_ready = first_flags[ptr_reg] && (!dual_mode_reg || second_flags[ptr_reg]);
  assign out_free = !tx_valid || tx_ready;
  assign emit = out_free && state_reg != tx_seq_pkg::ST_CHECK;
  assign last_beat = state_reg == tx_seq_pkg::ST_DATA && beat_reg == ctrl_reg[`CTL_QW_HI:`CTL_QW_LO];
  assign nbytes = {1'b0, ctrl_reg[`CTL_BYTES_HI:`CTL_BYTES_LO]} + 4'h1;
  assign clr_en = (state_reg == tx_seq_pkg::ST_CHECK && elem_ready && ptr_ctrl[`CTL_ERR]) ||
                  (emit && last_beat);
  assign clr_idx = state_reg == tx_seq_pkg::ST_CHECK ? ptr_reg : cur_reg;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state_reg <= tx_seq_pkg::ST_CHECK;
      ptr_reg <= `PTR_RESET;
      cur_reg <= 4'h0;
      ctrl_reg <= 64'h0;
      beat_reg <= 3'h0;
      first_beat_reg <= 1'b0;
    end
    else
    begin
      case (state_reg)
        tx_seq_pkg::ST_CHECK:
        begin
          // An unready element holds the pointer where it is.
          if (elem_ready)
          begin
            ptr_reg <= 4'(ptr_reg + 4'h1);
            if (!ptr_ctrl[`CTL_ERR])
            begin
              cur_reg <= ptr_reg;
              ctrl_reg <= ptr_ctrl;
              beat_reg <= 3'h0;
              first_beat_reg <= 1'b1;
              state_reg <= ptr_ctrl[`CTL_PREPEND] ? tx_seq_pkg::ST_PREPEND : tx_seq_pkg::ST_DATA;
            end
          end
        end
        tx_seq_pkg::ST_PREPEND:
        begin
          if (emit)
          begin
            first_beat_reg <= 1'b0;
            state_reg <= tx_seq_pkg::ST_DATA;
          end
        end
        tx_seq_pkg::ST_DATA:
        begin
          if (emit)
          begin
            first_beat_reg <= 1'b0;
            beat_reg <= 3'(beat_reg + 3'h1);
            if (last_beat)
              state_reg <= tx_seq_pkg::ST_CHECK;
          end
        end
        default:
          state_reg <= tx_seq_pkg::ST_CHECK;
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // Packet bus output stage
  // --------------------------------------------------------------------------
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      tx_valid <= 1'b0;
      tx_data <= 64'h0;
      tx_byte_valid <= 8'h00;
      tx_sop <= 1'b0;
      tx_eop <= 1'b0;
      tx_err <= 1'b0;
      tx_asis <= 1'b0;
      tx_mac <= 3'h0;
      tx_port <= 3'h0;
    end
    else if (emit)
    begin
      tx_valid <= 1'b1;
      tx_data <= state_reg == tx_seq_pkg::ST_PREPEND ? elem_mem[cur_reg][`QW_PREPEND] :
                 elem_mem[cur_reg][{1'b0, beat_reg}];
      tx_byte_valid <= last_beat ? 8'(16'h00FF >> (4'h8 - nbytes)) : 8'hFF;
      tx_sop <= first_beat_reg && ctrl_reg[`CTL_SOP];
      tx_eop <= last_beat && ctrl_reg[`CTL_EOP];
      tx_err <= last_beat && ctrl_reg[`CTL_TXERR];
      tx_asis <= first_beat_reg && ctrl_reg[`CTL_TXASIS];
      tx_mac <= ctrl_reg[`CTL_MAC_HI:`CTL_MAC_LO];
      tx_port <= ctrl_reg[`CTL_PORT_HI:`CTL_PORT_LO];
    end
    else if (tx_ready)
      tx_valid <= 1'b0;
  end

  // --------------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------------
  AST_STALL: assert property (@(posedge aclk) disable iff (!aresetn)
    state_reg == tx_seq_pkg::ST_CHECK && !elem_ready |=> ptr_reg == $past(ptr_reg))
    else $error("Pointer moved off an unready element.");

  AST_ADVANCE: assert property (@(posedge aclk) disable iff (!aresetn)
    state_reg == tx_seq_pkg::ST_CHECK && elem_ready |=> ptr_reg == 4'($past(ptr_reg) + 4'h1))
    else $error("Pointer did not advance by one.");

  AST_PREPEND: assert property (@(posedge aclk) disable iff (!aresetn)
    state_reg == tx_seq_pkg::ST_CHECK && elem_ready && !ptr_ctrl[`CTL_ERR] && ptr_ctrl[`CTL_PREPEND]
    |=> state_reg == tx_seq_pkg::ST_PREPEND)
    else $error("Prepend beat not started.");

  AST_DUAL: assert property (@(posedge aclk) disable iff (!aresetn)
    state_reg == tx_seq_pkg::ST_CHECK && dual_mode_reg && !second_flags[ptr_reg]
    |=> state_reg == tx_seq_pkg::ST_CHECK && $stable(ptr_reg))
    else $error("Element started without its second flag.");

  AST_CLEAR: assert property (@(posedge aclk) disable iff (!aresetn)
    clr_en && !first_set[clr_idx] |=> !first_flags[$past(clr_idx)])
    else $error("Valid flag not cleared after transmit.");

  // A beat of the previous element may still be waiting on the bus, so only a fresh beat is a fault.
  AST_ERR_SKIP: assert property (@(posedge aclk) disable iff (!aresetn)
    state_reg == tx_seq_pkg::ST_CHECK && elem_ready && ptr_ctrl[`CTL_ERR]
    |=> state_reg == tx_seq_pkg::ST_CHECK && (!tx_valid || $past(tx_valid) && $stable(tx_data)))
    else $error("Error element was transmitted.");

  AST_VALIDATE: assert property (@(posedge aclk) disable iff (!aresetn)
    validate_hit |=> first_flags[$past(validate_elem)])
    else $error("Validate write did not set the flag.");

  AST_SIGNAL: assert property (@(posedge aclk) disable iff (!aresetn)
    mem_done_valid |=> second_flags[$past(mem_done_elem)] && mem_thread_signal == $past(mem_done_sig_req))
    else $error("Memory completion not recorded.");

  AST_RESET: assert property (@(posedge aclk)
    !aresetn |=> ptr_reg == 4'h0 && first_flags == '0 && second_flags == '0)
    else $error("Reset did not clear sequencer state.");

  AST_PTR_READ: assert property (@(posedge aclk) disable iff (!aresetn)
    s_axi_arvalid && s_axi_arready && s_axi_araddr == {28'h0, `OFS_TX_POINTER}
    |=> s_axi_rdata[3:0] == $past(ptr_reg))
    else $error("Pointer register read mismatch.");

  AST_SOP_FIRST: assert property (@(posedge aclk) disable iff (!aresetn)
    emit && !first_beat_reg |=> !tx_sop)
    else $error("Start of packet on a later beat.");

endmodule : transmit_element_sequencer

// ===== tb/element_filler.sv
`timescale 1ns/1ps

// ----------------------------------------------------------------------------
// Filling threads and memory unit
// ----------------------------------------------------------------------------
module element_filler
(
  input wire logic aclk,
  output logic fill_valid,
  output logic [3:0] fill_elem,
  output logic [3:0] fill_qword,
  output logic [63:0] fill_data,
  output logic mem_done_valid,
  output logic [3:0] mem_done_elem,
  output logic mem_done_sig_req
);
  initial
  begin
    fill_valid = 1'b0;
    fill_elem = 4'h0;
    fill_qword = 4'h0;
    fill_data = 64'h0;
    mem_done_valid = 1'b0;
    mem_done_elem = 4'h0;
    mem_done_sig_req = 1'b0;
  end

  // The gap lets a thread answer slowly; the idle bus shows inverted data so stale words never look current.
  task put_qword(input logic [3:0] e, input logic [3:0] q, input logic [63:0] d, input logic [1:0] gap);
    repeat (gap + 1) @(posedge aclk);
    fill_valid <= 1'b1;
    fill_elem <= e;
    fill_qword <= q;
    fill_data <= d;
    @(posedge aclk);
    fill_valid <= 1'b0;
    fill_data <= ~d;
  endtask : put_qword

  task mem_done(input logic [3:0] e);
    @(posedge aclk);
    mem_done_valid <= 1'b1;
    mem_done_elem <= e;
    mem_done_sig_req <= 1'b1;
    @(posedge aclk);
    mem_done_valid <= 1'b0;
    mem_done_elem <= ~e;
    mem_done_sig_req <= 1'b0;
  endtask : mem_done
endmodule : element_filler

// ===== tb/transmit_element_sequencer_tb_top.sv
`timescale 1ns/1ps
`include "tx_seq_defs.svh"

module transmit_element_sequencer_tb_top;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, s_axi_araddr = 32'h0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic fill_valid, mem_done_valid, mem_done_sig_req, mem_thread_signal, tx_valid;
  logic [3:0] fill_elem, fill_qword, mem_done_elem, mem_thread_elem;
  logic [63:0] fill_data, tx_data;
  logic tx_ready = 1'b0;
  logic [7:0] tx_byte_valid;
  logic tx_sop, tx_eop, tx_err, tx_asis;
  logic [2:0] tx_mac, tx_port;
  logic [81:0] exp_q[$];
  logic [63:0] store [16][8];
  logic [16:0] seed = 17'h17DEC;
  logic [16:0] rseed = 17'h17DEC;
  int fails = 0;
  int n_compared = 0;
  int cycles = 0;
  int i;

  always #12.5 aclk = ~aclk;

  transmit_element_sequencer uut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'hF),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .fill_valid(fill_valid), .fill_elem(fill_elem), .fill_qword(fill_qword), .fill_data(fill_data),
    .mem_done_valid(mem_done_valid), .mem_done_elem(mem_done_elem), .mem_done_sig_req(mem_done_sig_req),
    .mem_thread_signal(mem_thread_signal), .mem_thread_elem(mem_thread_elem), .tx_valid(tx_valid),
    .tx_ready(tx_ready), .tx_data(tx_data), .tx_byte_valid(tx_byte_valid), .tx_sop(tx_sop), .tx_eop(tx_eop),
    .tx_err(tx_err), .tx_asis(tx_asis), .tx_mac(tx_mac), .tx_port(tx_port));

  element_filler filler (.aclk(aclk), .fill_valid(fill_valid), .fill_elem(fill_elem), .fill_qword(fill_qword),
    .fill_data(fill_data), .mem_done_valid(mem_done_valid), .mem_done_elem(mem_done_elem),
    .mem_done_sig_req(mem_done_sig_req));

  function automatic logic [16:0] lfsr(input logic [16:0] s);
    return {s[15:0], s[16] ^ s[13]};
  endfunction : lfsr

  task check(input string name, input logic [81:0] seen, input logic [81:0] expected);
    n_compared++;
    if (seen !== expected)
    begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", name, expected, seen);
    end
  endtask : check

  task conclude;
    if (fails == 0 && n_compared > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : conclude

  // ----------------------------------------------------------------------------
  // Register bus master
  // ----------------------------------------------------------------------------
  task axi_write(input logic [31:0] a, input logic [31:0] d, input logic [1:0] er);
    logic aw_p, w_p, aw_t, w_t;
    aw_p = 1'b1;
    w_p = 1'b1;
    // One edge between transfers keeps a handshake signal from being driven twice in one time step.
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (aw_p || w_p)
    begin
      @(negedge aclk);
      aw_t = aw_p && s_axi_awready === 1'b1;
      w_t = w_p && s_axi_wready === 1'b1;
      @(posedge aclk);
      aw_p = aw_p && !aw_t;
      w_p = w_p && !w_t;
      s_axi_awvalid <= aw_p;
      s_axi_wvalid <= w_p;
    end
    do @(negedge aclk); while (s_axi_bvalid !== 1'b1);
    check("bresp", s_axi_bresp, er);
    @(posedge aclk);
    s_axi_bready <= 1'b0;
  endtask : axi_write

  task axi_read(input logic [31:0] a, input logic [31:0] ed, input logic [1:0] er);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(negedge aclk); while (s_axi_arready !== 1'b1);
    @(posedge aclk);
    s_axi_arvalid <= 1'b0;
    do @(negedge aclk); while (s_axi_rvalid !== 1'b1);
    check("rdata_rresp", {s_axi_rdata, s_axi_rresp}, {ed, er});
    @(posedge aclk);
    s_axi_rready <= 1'b0;
  endtask : axi_read

  // ----------------------------------------------------------------------------
  // Element loading and expected beats
  // ----------------------------------------------------------------------------
  task load(input logic [3:0] e, input logic skip);
    logic [63:0] c, p, d;
    logic [7:0] bv;
    int q;
    for (q = 0; q < 8; q++)
    begin
      seed = lfsr(seed);
      store[e][q] = {seed[14:0], seed, 20'h0, e, 4'h0, 4'(q)};
      filler.put_qword(e, 4'(q), store[e][q], seed[1:0]);
    end
    seed = lfsr(seed);
    p = {seed, seed[14:0], 32'hFACE0000};
    filler.put_qword(e, `QW_PREPEND, p, seed[1:0]);
    seed = lfsr(seed);
    c = {45'h0, seed[16:6], skip, 1'b0, seed[5:0]};
    filler.put_qword(e, `QW_CONTROL, c, seed[1:0]);
    if (!skip && c[16])
      exp_q.push_back({p, 8'hFF, c[8], 1'b0, c[17], 1'b0, c[5:0]});
    for (q = 0; q <= int'(c[15:13]) && !skip; q++)
    begin
      bv = (q == int'(c[15:13])) ? 8'hFF >> (3'h7 - c[12:10]) : 8'hFF;
      d = store[e][q];
      exp_q.push_back({d, bv, c[8] && !c[16] && q == 0, c[9] && q == int'(c[15:13]),
        c[17] && !c[16] && q == 0, c[18] && q == int'(c[15:13]), c[5:0]});
    end
  endtask : load

  task validate(input logic [3:0] e);
    axi_write({28'h0, `OFS_VALIDATE}, {28'h0, e}, `RESP_OKAY);
  endtask : validate

  // ----------------------------------------------------------------------------
  // Packet sink, beat monitor and timeout
  // ----------------------------------------------------------------------------
  always @(posedge aclk)
  begin
    rseed <= lfsr(rseed);
    tx_ready <= rseed[0] | rseed[1];
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      fails++;
      conclude();
    end
    else if (aresetn && tx_valid === 1'b1 && tx_ready === 1'b1)
    begin
      if (exp_q.size() == 0)
        check("tx_extra_beat", 82'h1, 82'h0);
      else
        check("tx_beat", {tx_data, tx_byte_valid, tx_sop, tx_eop, tx_asis, tx_err, tx_mac, tx_port},
          exp_q.pop_front());
    end
  end

  initial
  begin
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    axi_read({28'h0, `OFS_TX_POINTER}, 32'h0, `RESP_OKAY);
    axi_read({28'h0, `OFS_VALID_FLAGS}, 32'h0, `RESP_OKAY);
    axi_read(32'h10, 32'h0, `RESP_SLVERR);
    axi_write({28'h0, `OFS_TX_POINTER}, 32'h5, `RESP_SLVERR);
    load(4'h0, 1'b0);
    repeat (20) @(posedge aclk);
    check("tx_valid_stalled", tx_valid, 1'b0);
    axi_read({28'h0, `OFS_TX_POINTER}, 32'h0, `RESP_OKAY);
    validate(4'h0);
    repeat (4) @(posedge aclk);
    axi_read({28'h0, `OFS_TX_POINTER}, 32'h1, `RESP_OKAY);
    for (i = 1; i < 19; i++)
    begin
      load(4'(i), i == 5);
      if (i % 9 == 0)
      begin
        for (int j = i - 8; j <= i; j++)
          validate(4'(j));
        while (exp_q.size() != 0) @(posedge aclk);
      end
    end
    repeat (4) @(posedge aclk);
    axi_read({28'h0, `OFS_VALID_FLAGS}, 32'h0, `RESP_OKAY);
    axi_read({28'h0, `OFS_TX_POINTER}, 32'h3, `RESP_OKAY);
    axi_write({28'h0, `OFS_MODE_CTRL}, 32'h1, `RESP_OKAY);
    load(4'h3, 1'b0);
    validate(4'h3);
    repeat (10) @(posedge aclk);
    check("tx_valid_dual", tx_valid, 1'b0);
    axi_read({28'h0, `OFS_VALID_FLAGS}, 32'h8, `RESP_OKAY);
    filler.mem_done(4'h3);
    @(negedge aclk);
    check("thread_signal", {mem_thread_signal, mem_thread_elem}, 5'h13);
    @(posedge aclk);
    while (exp_q.size() != 0) @(posedge aclk);
    repeat (4) @(posedge aclk);
    axi_read({28'h0, `OFS_VALID_FLAGS}, 32'h0, `RESP_OKAY);
    axi_read({28'h0, `OFS_TX_POINTER}, 32'h4, `RESP_OKAY);
    conclude();
  end
endmodule : transmit_element_sequencer_tb_top
